//--- fir_eq_pkg.sv
// Purpose: shared constants, register map and carrier types of the equalizing fir block
// Assumes: register indices scaled by four give the apb byte address
// Notes:   coefficient and sample words are signed two's complement
package fir_eq_pkg;

  // datapath widths
  localparam int SMP_W   = 12;
  localparam int SIDE_W  = 12;
  localparam int CTR_W   = 18;
  localparam int NTAPS   = 9;
  localparam int CTR_TAP = 4;
  localparam int HIST_N  = NTAPS - 1;
  localparam int ACC_W   = 36;
  localparam int OUT_SHIFT = 16;
  localparam int ADDR_W  = 16;

  // saturation limits in accumulator width
  localparam logic signed [ACC_W-1:0] SAT_MAX = 36'sh0_0000_07ff;
  localparam logic signed [ACC_W-1:0] SAT_MIN = -36'sh0_0000_0800;
  localparam logic [CTR_W-1:0]        CTR_ONE = 18'h10000;

  // register indices
  localparam logic [11:0] IDX_FIR_CONFIG = 12'h400;
  localparam logic [11:0] IDX_LINK_CTRL  = 12'h401;
  localparam logic [11:0] IDX_STATUS     = 12'h402;
  localparam logic [11:0] IDX_TAP0       = 12'h418;
  localparam logic [11:0] IDX_TAP1       = 12'h41a;

  // byte addresses on apb
  localparam logic [ADDR_W-1:0] ADDR_FIR_CONFIG = {2'b00, IDX_FIR_CONFIG, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_LINK_CTRL  = {2'b00, IDX_LINK_CTRL, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_STATUS     = {2'b00, IDX_STATUS, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_TAP0       = {2'b00, IDX_TAP0, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_TAP1       = {2'b00, IDX_TAP1, 2'b00};

  // reset values
  localparam logic [7:0]  CFG_RESET  = 8'h00;
  localparam logic [15:0] TAP_RESET  = 16'h0000;
  localparam logic        LINK_RESET = 1'b0;

  // status bit positions
  localparam int STAT_ON_BIT    = 0;
  localparam int STAT_MERGE_BIT = 1;
  localparam int STAT_SHARE_BIT = 2;
  localparam int STAT_VIOL_BIT  = 3;
  localparam int LINK_EN_BIT    = 0;

  typedef enum logic [1:0] {
    MODE_OFF   = 2'b00,
    MODE_RSVD1 = 2'b01,
    MODE_ON    = 2'b10,
    MODE_RSVD3 = 2'b11
  } filter_mode_t;

  typedef struct packed {
    logic         reserved;
    logic         coeff_share_enable;
    logic         filter_merge_enable;
    logic [2:0]   side_coeff_weight;
    filter_mode_t filter_mode_select;
  } fir_config_t;

  typedef struct packed {
    logic [NTAPS-1:0][CTR_W-1:0] tap;
  } coeff_set_t;

  typedef logic [NTAPS-1:0][SMP_W-1:0]  window_t;
  typedef logic [HIST_N-1:0][SMP_W-1:0] history_t;

  typedef struct packed {
    logic             valid;
    logic [SMP_W-1:0] a;
    logic [SMP_W-1:0] b;
  } sample_pair_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
    logic [3:0]        pstrb;
  } apb_req_t;

endpackage

//--- fir_tap_sum.sv
// Purpose: nine-tap dot product with programmable side weight and saturation
// Assumes: side taps use the low twelve coefficient bits, center tap all eighteen
// Notes:   purely combinational; the caller registers the result
`timescale 1ns/1ps
module fir_tap_sum (
  // window and coefficients
  input  wire fir_eq_pkg::window_t    win_i,
  input  wire fir_eq_pkg::coeff_set_t coeff_i,
  input  wire logic [2:0]             scw_i,
  // filtered sample
  output logic [fir_eq_pkg::SMP_W-1:0] y_o
);
  import fir_eq_pkg::*;

  logic signed [ACC_W-1:0]        side_acc;
  logic signed [ACC_W-1:0]        acc;
  logic signed [ACC_W-1:0]        shifted;
  logic signed [2*SMP_W-1:0]      prod;
  logic signed [SMP_W+CTR_W-1:0]  ctr_prod;

  // side taps share one weight, center tap is fixed at 2^-16
  always_comb begin
    side_acc = '0;
    prod     = '0;
    for (int k = 0; k < NTAPS; k++) begin
      if (k != CTR_TAP) begin
        prod     = $signed(win_i[k]) * $signed(coeff_i.tap[k][SIDE_W-1:0]);
        side_acc = side_acc + ACC_W'(prod);
      end
    end
    ctr_prod = $signed(win_i[CTR_TAP]) * $signed(coeff_i.tap[CTR_TAP]);
    acc      = ACC_W'(ctr_prod) + (side_acc <<< scw_i);
    shifted  = acc >>> OUT_SHIFT;
    // clip rather than wrap, a wrapped equalizer output is a full-scale spike
    if (shifted > SAT_MAX) begin
      y_o = SAT_MAX[SMP_W-1:0];
    end else if (shifted < SAT_MIN) begin
      y_o = SAT_MIN[SMP_W-1:0];
    end else begin
      y_o = shifted[SMP_W-1:0];
    end
  end

endmodule

//--- programmable_fir_equalizer.sv
// Purpose: apb register file and dual-channel sample path of the equalizing fir
// Assumes: samples arrive on ref_clk_i, one a/b pair per valid cycle, a older than b
// Notes:   taps 2..8 of set a and all of set b come from the wider register file
`timescale 1ns/1ps
// Overview of operation
// - share bit set makes channel b use the channel a coefficients, else its own unless the merge bit is set.
// - merge bit joins both filters into one filter over one continuous sample stream.
// - three-bit side weight sets side coefficient lsb to two to the field minus sixteen.
// - mode field zero disables, two enables; one and three are reserved.
// - first tap is twelve-bit signed, for channel a or the merged filter.
// - second tap is twelve-bit signed with the same channel assignment.
// - configuration register resets to zero, everything inactive.
// - nine taps per filter; center tap eighteen bits signed, others twelve.
module programmable_fir_equalizer (
  // clock and reset
  input  wire logic                   ref_clk_i,
  input  wire logic                   rst_i,
  // apb slave
  input  wire fir_eq_pkg::apb_req_t   apb_i,
  output logic [31:0]                 prdata_o,
  output logic                        pready_o,
  output logic                        pslverr_o,
  // coefficients held elsewhere
  input  wire fir_eq_pkg::coeff_set_t coeff_a_ext_i,
  input  wire fir_eq_pkg::coeff_set_t coeff_b_i,
  // sample stream
  input  wire fir_eq_pkg::sample_pair_t sample_i,
  output fir_eq_pkg::sample_pair_t    sample_o,
  // state to the rest of the chip
  output logic                        serial_link_enable_o,
  output logic                        filter_active_o
);
  import fir_eq_pkg::*;

  fir_config_t  cfg_ff, nxt_cfg;
  logic [15:0]  tap0_ff, nxt_tap0;
  logic [15:0]  tap1_ff, nxt_tap1;
  logic         link_en_ff, nxt_link_en;
  logic         viol_ff, nxt_viol;
  logic [31:0]  prdata_ff, nxt_prdata;
  logic         pslverr_ff, nxt_pslverr;
  history_t     hist_a_ff, nxt_hist_a;
  history_t     hist_b_ff, nxt_hist_b;
  sample_pair_t out_ff, nxt_out;
  logic         sel_cfg, sel_link, sel_stat, sel_tap0, sel_tap1, mapped;
  logic [31:0]  rd_val;
  logic [15:0]  wmask;
  logic         setup, wr_acc, filter_on, merge_on;
  coeff_set_t   coeff_a, coeff_b;
  window_t      win_a, win_b;
  logic [SMP_W-1:0] y_a, y_b;
  logic         ext_side_zero;

  // address decode and read mux
  always_comb begin
    sel_cfg  = 1'b0;
    sel_link = 1'b0;
    sel_stat = 1'b0;
    sel_tap0 = 1'b0;
    sel_tap1 = 1'b0;
    mapped   = 1'b1;
    rd_val   = 32'h0000_0000;
    if (apb_i.paddr == ADDR_FIR_CONFIG) begin
      sel_cfg = 1'b1;
      rd_val  = {24'h00_0000, cfg_ff};
    end else if (apb_i.paddr == ADDR_LINK_CTRL) begin
      sel_link = 1'b1;
      rd_val[LINK_EN_BIT] = link_en_ff;
    end else if (apb_i.paddr == ADDR_STATUS) begin
      sel_stat = 1'b1;
      rd_val[STAT_ON_BIT]    = filter_on;
      rd_val[STAT_MERGE_BIT] = merge_on;
      rd_val[STAT_SHARE_BIT] = cfg_ff.coeff_share_enable;
      rd_val[STAT_VIOL_BIT]  = viol_ff;
    end else if (apb_i.paddr == ADDR_TAP0) begin
      sel_tap0 = 1'b1;
      rd_val   = {16'h0000, tap0_ff};
    end else if (apb_i.paddr == ADDR_TAP1) begin
      sel_tap1 = 1'b1;
      rd_val   = {16'h0000, tap1_ff};
    end else begin
      mapped = 1'b0;
    end
  end

  // zero-wait slave: read data is latched in the setup cycle
  assign setup    = apb_i.psel & ~apb_i.penable;
  assign wr_acc   = apb_i.psel & apb_i.penable & apb_i.pwrite;
  assign wmask    = {{8{apb_i.pstrb[1]}}, {8{apb_i.pstrb[0]}}};
  assign pready_o = 1'b1;

  // register next values; writes land on the access edge only
  always_comb begin
    nxt_cfg     = cfg_ff;
    nxt_tap0    = tap0_ff;
    nxt_tap1    = tap1_ff;
    nxt_link_en = link_en_ff;
    nxt_prdata  = prdata_ff;
    nxt_pslverr = pslverr_ff;
    if (wr_acc && sel_cfg && apb_i.pstrb[0]) begin
      nxt_cfg = fir_config_t'(apb_i.pwdata[7:0]);
    end
    if (wr_acc && sel_tap0) begin
      nxt_tap0 = (tap0_ff & ~wmask) | (apb_i.pwdata[15:0] & wmask);
    end
    if (wr_acc && sel_tap1) begin
      nxt_tap1 = (tap1_ff & ~wmask) | (apb_i.pwdata[15:0] & wmask);
    end
    if (wr_acc && sel_link && apb_i.pstrb[0]) begin
      nxt_link_en = apb_i.pwdata[LINK_EN_BIT];
    end
    if (setup) begin
      nxt_prdata  = rd_val;
      nxt_pslverr = ~mapped;
    end
  end

  // sticky flag for filter writes made while the link runs; a new hit beats the clear
  always_comb begin
    nxt_viol = viol_ff;
    if (wr_acc && sel_stat && apb_i.pstrb[0] && apb_i.pwdata[STAT_VIOL_BIT]) begin
      nxt_viol = 1'b0;
    end
    if (wr_acc && link_en_ff && (sel_cfg || sel_tap0 || sel_tap1)) begin
      nxt_viol = 1'b1;
    end
  end

  // register state
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cfg_ff     <= fir_config_t'(CFG_RESET);
      tap0_ff    <= TAP_RESET;
      tap1_ff    <= TAP_RESET;
      link_en_ff <= LINK_RESET;
      viol_ff    <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      cfg_ff     <= nxt_cfg;
      tap0_ff    <= nxt_tap0;
      tap1_ff    <= nxt_tap1;
      link_en_ff <= nxt_link_en;
      viol_ff    <= nxt_viol;
      prdata_ff  <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  assign prdata_o             = prdata_ff;
  assign pslverr_o            = pslverr_ff;
  assign serial_link_enable_o = link_en_ff;
  assign filter_on            = (cfg_ff.filter_mode_select == MODE_ON);
  assign merge_on             = cfg_ff.filter_merge_enable;
  assign filter_active_o      = filter_on;

  // coefficient sets; the merged filter runs on set a at both positions
  always_comb begin
    coeff_a        = coeff_a_ext_i;
    coeff_a.tap[0] = CTR_W'($signed(tap0_ff[SIDE_W-1:0]));
    coeff_a.tap[1] = CTR_W'($signed(tap1_ff[SIDE_W-1:0]));
    if (cfg_ff.coeff_share_enable || merge_on) begin
      coeff_b = coeff_a;
    end else begin
      coeff_b = coeff_b_i;
    end
  end

  // windows: tap k sees the sample k steps back in its stream
  always_comb begin
    win_a[0] = sample_i.a;
    win_b[0] = sample_i.b;
    for (int k = 1; k < NTAPS; k++) begin
      win_a[k] = hist_a_ff[k-1];
      win_b[k] = hist_b_ff[k-1];
    end
    if (merge_on) begin
      win_b[1] = sample_i.a;
      for (int k = 2; k < NTAPS; k++) begin
        win_b[k] = hist_a_ff[k-2];
      end
    end
  end

  // history shifts by two per pair when merged, by one per channel otherwise
  always_comb begin
    nxt_hist_a = hist_a_ff;
    nxt_hist_b = hist_b_ff;
    if (sample_i.valid) begin
      if (merge_on) begin
        nxt_hist_a[0] = sample_i.b;
        nxt_hist_a[1] = sample_i.a;
        for (int k = 2; k < HIST_N; k++) begin
          nxt_hist_a[k] = hist_a_ff[k-2];
        end
      end else begin
        nxt_hist_a[0] = sample_i.a;
        nxt_hist_b[0] = sample_i.b;
        for (int k = 1; k < HIST_N; k++) begin
          nxt_hist_a[k] = hist_a_ff[k-1];
          nxt_hist_b[k] = hist_b_ff[k-1];
        end
      end
    end
  end

  // nine-tap sums, one per output position
  fir_tap_sum u_sum_a (
    .win_i   (win_a),
    .coeff_i (coeff_a),
    .scw_i   (cfg_ff.side_coeff_weight),
    .y_o     (y_a)
  );

  fir_tap_sum u_sum_b (
    .win_i   (win_b),
    .coeff_i (coeff_b),
    .scw_i   (cfg_ff.side_coeff_weight),
    .y_o     (y_b)
  );

  // output stage; bypass has the same one-cycle latency so switching keeps alignment
  always_comb begin
    nxt_out       = out_ff;
    nxt_out.valid = sample_i.valid;
    if (sample_i.valid) begin
      if (filter_on) begin
        nxt_out.a = y_a;
        nxt_out.b = y_b;
      end else begin
        nxt_out.a = sample_i.a;
        nxt_out.b = sample_i.b;
      end
    end
  end

  // sample path state
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      hist_a_ff <= '0;
      hist_b_ff <= '0;
      out_ff    <= '0;
    end else begin
      hist_a_ff <= nxt_hist_a;
      hist_b_ff <= nxt_hist_b;
      out_ff    <= nxt_out;
    end
  end

  assign sample_o = out_ff;

  // helper: external taps 2 to 8 other than the center are all zero
  always_comb begin
    ext_side_zero = 1'b1;
    for (int k = 2; k < NTAPS; k++) begin
      if (k != CTR_TAP && coeff_a_ext_i.tap[k] != '0) begin
        ext_side_zero = 1'b0;
      end
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  a_share_same_out: assert property (cfg_ff.coeff_share_enable && !merge_on && filter_on && sample_i.valid
    && win_a == win_b |=> sample_o.a == sample_o.b) else $error("shared sets gave different outputs");
  a_own_set_b: assert property (!cfg_ff.coeff_share_enable && !merge_on |-> coeff_b == coeff_b_i)
    else $error("channel b not on its own set");
  a_merge_stream: assert property (merge_on && sample_i.valid |=> hist_a_ff[0] == $past(sample_i.b)
    && hist_a_ff[1] == $past(sample_i.a) && hist_a_ff[2] == $past(hist_a_ff[0])) else $error("merged stream order");
  a_side_weight: assert property (filter_on && !merge_on && sample_i.valid && cfg_ff.side_coeff_weight == 3'h6
    && tap0_ff[11:0] == 12'h400 && tap1_ff[11:0] == 12'h000 && ext_side_zero && coeff_a_ext_i.tap[CTR_TAP] == '0
    |=> sample_o.a == $past(sample_i.a)) else $error("side weight scaling wrong");
  a_mode_status: assert property (setup && apb_i.paddr == ADDR_STATUS
    |=> prdata_o[STAT_ON_BIT] == (cfg_ff.filter_mode_select == MODE_ON)) else $error("status shows wrong mode");
  a_tap0_write: assert property (wr_acc && sel_tap0 && apb_i.pstrb == 4'hf
    |=> tap0_ff == $past(apb_i.pwdata[15:0])) else $error("tap0 write lost");
  a_tap1_sext: assert property (coeff_a.tap[1] == {{6{tap1_ff[11]}}, tap1_ff[11:0]})
    else $error("tap1 not sign extended");
  a_cfg_reset: assert property ($fell(rst_i) |-> cfg_ff == fir_config_t'(CFG_RESET) && !filter_active_o
    && !sample_o.valid) else $error("config not cleared by reset");
  a_center_unity: assert property (filter_on && !merge_on && sample_i.valid && tap0_ff[11:0] == 12'h000
    && tap1_ff[11:0] == 12'h000 && ext_side_zero && coeff_a_ext_i.tap[CTR_TAP] == CTR_ONE
    |=> sample_o.a == $past(hist_a_ff[3])) else $error("center tap not fifth sample");
  a_bypass_pass: assert property (!filter_on && sample_i.valid
    |=> sample_o.valid && sample_o.a == $past(sample_i.a) && sample_o.b == $past(sample_i.b))
    else $error("bypass altered samples");

  c_filter_run: cover property (filter_on && sample_i.valid ##1 sample_o.valid);
  c_merge_run: cover property (merge_on && filter_on && sample_i.valid ##2 sample_i.valid ##2 sample_i.valid);
  c_viol_flag: cover property (!viol_ff ##1 viol_ff);
  c_unmapped: cover property (setup && !mapped ##1 pslverr_o);

endmodule

//--- programmable_fir_equalizer_bench.sv
// Purpose: self-checking bench of the equalizing fir register file and sample path
// Assumes: zero-wait apb slave, one-cycle sample latency, history advances on every valid
// Notes:   expected samples come from a bench-side reference sum or, in bypass, the input pair, never from the design
`timescale 1ns/1ps
module programmable_fir_equalizer_bench;
  import fir_eq_pkg::*;

  typedef struct packed {
    logic [7:0] cfg;
    logic       act;
  } mode_row_t;

  logic         ref_clk_i = 1'b0;
  logic         rst_i     = 1'b1;
  apb_req_t     apb_i     = '0;
  coeff_set_t   coeff_a_ext_i;
  coeff_set_t   coeff_b_i;
  sample_pair_t sample_i  = '0;
  sample_pair_t sample_o;
  logic [31:0]  prdata_o;
  logic         pready_o;
  logic         pslverr_o;
  logic         serial_link_enable_o;
  logic         filter_active_o;
  int           err_count = 0;
  int           n_checks  = 0;
  int           cyc       = 0;
  int           sc        = 0;
  window_t      ha        = '0;
  window_t      hb        = '0;
  logic [7:0]   cfg_cur   = '0;
  logic [15:0]  tap0_cur  = '0;
  logic [15:0]  tap1_cur  = '0;
  logic         same_ab   = 1'b0;

  // external set a with only the center tap at unity, side taps zero
  localparam coeff_set_t UNIT_CTR = coeff_set_t'({{(NTAPS-CTR_TAP-1)*CTR_W{1'b0}}, CTR_ONE, {CTR_TAP*CTR_W{1'b0}}});

  // configuration rows: register value and expected enable decode
  localparam mode_row_t ROWS [10] = '{
    '{8'h00, 1'b0}, '{8'h01, 1'b0}, '{8'h03, 1'b0},   // off and both reserved codes
    '{8'h02, 1'b0 | 1'b1}, '{8'h0e, 1'b1}, '{8'h1a, 1'b1},
    '{8'h42, 1'b1}, '{8'h22, 1'b1}, '{8'h62, 1'b1},
    '{8'h82, 1'b1}                                    // reserved bit is plain storage
  };

  programmable_fir_equalizer programmable_fir_equalizer_i (
    .ref_clk_i            (ref_clk_i),
    .rst_i                (rst_i),
    .apb_i                (apb_i),
    .prdata_o             (prdata_o),
    .pready_o             (pready_o),
    .pslverr_o            (pslverr_o),
    .coeff_a_ext_i        (coeff_a_ext_i),
    .coeff_b_i            (coeff_b_i),
    .sample_i             (sample_i),
    .sample_o             (sample_o),
    .serial_link_enable_o (serial_link_enable_o),
    .filter_active_o      (filter_active_o)
  );

  // free-running clock, 10 ns period
  always #5 ref_clk_i = ~ref_clk_i;

  // watchdog: the whole run needs well under two thousand cycles
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      $display("MISMATCH watchdog expected finish seen hang");
      err_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (err_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask

  // one apb transfer; request held until pready is seen high at an edge
  task automatic apb(input logic is_wr, input logic [15:0] ad, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    @(posedge ref_clk_i);
    apb_i <= '{psel: 1'b1, penable: 1'b0, pwrite: is_wr, paddr: ad, pwdata: wd, pstrb: 4'hf};
    @(posedge ref_clk_i);
    apb_i.penable <= 1'b1;
    do @(posedge ref_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    apb_i.psel    <= 1'b0;
    apb_i.penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] ad, input logic [31:0] wd);
    logic [31:0] d;
    logic        e;
    apb(1'b1, ad, wd, d, e);
  endtask

  task automatic rd_chk(input string nm, input logic [15:0] ad, input logic [31:0] exp, input logic expe);
    logic [31:0] d;
    logic        e;
    apb(1'b0, ad, 32'h0, d, e);
    chk(nm, exp, d);
    chk({nm, " pslverr"}, 32'(expe), 32'(e));
  endtask

  // reference sum: side taps use twelve bits scaled by the weight, center all eighteen
  function automatic logic [11:0] ref_y(input window_t w, input coeff_set_t c, input logic [2:0] s);
    longint side;
    longint acc;
    side = 0;
    for (int k = 0; k < NTAPS; k++)
      if (k != CTR_TAP) side += longint'($signed(c.tap[k][11:0])) * longint'($signed(w[k]));
    acc = (side <<< s) + longint'($signed(c.tap[CTR_TAP])) * longint'($signed(w[CTR_TAP]));
    acc = acc >>> 16;
    if (acc > 2047) acc = 2047;
    if (acc < -2048) acc = -2048;
    return 12'(acc);
  endfunction

  // one sample pair in, result checked one cycle later; valid drops for a cycle after
  task automatic send(input logic chk_on);
    logic [11:0] a, b, ea, eb;
    window_t     wa, wb;
    coeff_set_t  ca, cb;
    a = 12'(sc * 613 + 1000);
    b = 12'(sc * 1877) ^ 12'h5a5;
    // equal streams let the shared-set case compare the two channels directly
    if (same_ab) begin
      b = a;
    end
    sc++;
    @(posedge ref_clk_i);
    sample_i <= '{valid: 1'b1, a: a, b: b};
    ha = {ha[HIST_N-1:0], a};
    hb = {hb[HIST_N-1:0], b};
    ca = coeff_a_ext_i;
    ca.tap[0] = 18'(tap0_cur[11:0]);
    ca.tap[1] = 18'(tap1_cur[11:0]);
    cb = (cfg_cur[6] | cfg_cur[5]) ? ca : coeff_b_i;
    wa = ha;
    wb = hb;
    // merged view interleaves the two histories, a older than b
    if (cfg_cur[5]) begin
      for (int k = 0; k < NTAPS; k++) begin
        wa[k] = (k % 2) ? hb[(k + 1) / 2] : ha[k / 2];
        wb[k] = (k % 2) ? ha[(k - 1) / 2] : hb[k / 2];
      end
    end
    ea = (cfg_cur[1:0] == 2'b10) ? ref_y(wa, ca, cfg_cur[4:2]) : a;
    eb = (cfg_cur[1:0] == 2'b10) ? ref_y(wb, cb, cfg_cur[4:2]) : b;
    @(posedge ref_clk_i);
    sample_i.valid <= 1'b0;
    #1;
    if (chk_on) begin
      chk("sample_o.valid", 32'h1, 32'(sample_o.valid));
      chk("sample_o.a", 32'(ea), 32'(sample_o.a));
      chk("sample_o.b", 32'(eb), 32'(sample_o.b));
    end
  endtask

  initial begin
    // mixed-sign side taps on set a, non-negative on set b; centers near one and minus a quarter
    for (int k = 0; k < NTAPS; k++) begin
      coeff_a_ext_i.tap[k] = 18'h00800 - 18'(k * 300);
      coeff_b_i.tap[k]     = 18'(k * 157);
    end
    coeff_a_ext_i.tap[CTR_TAP] = 18'h10000;
    coeff_b_i.tap[CTR_TAP]     = 18'h3c000;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    rd_chk("fir_config", ADDR_FIR_CONFIG, 32'h0, 1'b0);
    rd_chk("tap0", ADDR_TAP0, 32'h0, 1'b0);
    rd_chk("tap1", ADDR_TAP1, 32'h0, 1'b0);
    chk("filter_active_o", 32'h0, 32'(filter_active_o));
    rd_chk("unmapped", 16'h2000, 32'h0, 1'b1);
    // coefficients go in before any enable, link held off until the sticky-flag check
    wr(ADDR_TAP0, 32'h0000f123);
    tap0_cur = 16'hf123;
    wr(ADDR_TAP1, 32'h00000e80);
    tap1_cur = 16'h0e80;
    rd_chk("tap0", ADDR_TAP0, 32'h0000f123, 1'b0);
    rd_chk("tap1", ADDR_TAP1, 32'h00000e80, 1'b0);
    // each row flushes nine pairs through before checking six back to back
    foreach (ROWS[i]) begin
      wr(ADDR_FIR_CONFIG, 32'(ROWS[i].cfg));
      cfg_cur = ROWS[i].cfg;
      rd_chk("fir_config", ADDR_FIR_CONFIG, 32'(ROWS[i].cfg), 1'b0);
      chk("filter_active_o", 32'(ROWS[i].act), 32'(filter_active_o));
      repeat (9) send(1'b0);
      repeat (6) send(1'b1);
    end
    // center tap alone at unity: output is the sample four steps back
    @(posedge ref_clk_i);
    coeff_a_ext_i <= UNIT_CTR;
    wr(ADDR_TAP0, 32'h0);
    tap0_cur = 16'h0000;
    wr(ADDR_TAP1, 32'h0);
    tap1_cur = 16'h0000;
    wr(ADDR_FIR_CONFIG, 32'h02);
    cfg_cur = 8'h02;
    repeat (9) send(1'b0);
    repeat (4) send(1'b1);
    // first tap alone at side weight six: unity gain on the newest sample
    @(posedge ref_clk_i);
    coeff_a_ext_i <= '0;
    wr(ADDR_TAP0, 32'h400);
    tap0_cur = 16'h0400;
    wr(ADDR_FIR_CONFIG, 32'h1a);
    cfg_cur = 8'h1a;
    repeat (9) send(1'b0);
    repeat (4) send(1'b1);
    // shared set with equal channel streams must give equal outputs
    wr(ADDR_FIR_CONFIG, 32'h42);
    cfg_cur = 8'h42;
    same_ab = 1'b1;
    repeat (9) send(1'b0);
    repeat (4) send(1'b1);
    same_ab = 1'b0;
    // write with the link running raises the sticky flag; ro bits ignore writes
    wr(ADDR_LINK_CTRL, 32'h1);
    // the enable flop updates on the edge that ends the write; look once it has settled
    #1;
    chk("serial_link_enable_o", 32'h1, 32'(serial_link_enable_o));
    wr(ADDR_FIR_CONFIG, 32'h62);
    rd_chk("status", ADDR_STATUS, 32'hf, 1'b0);
    wr(ADDR_STATUS, 32'hf);
    rd_chk("status", ADDR_STATUS, 32'h7, 1'b0);
    // second reset in mid-run with the filter enabled
    @(posedge ref_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    #1;
    chk("sample_o", 32'h0, 32'(sample_o));
    chk("filter_active_o", 32'h0, 32'(filter_active_o));
    chk("serial_link_enable_o", 32'h0, 32'(serial_link_enable_o));
    rd_chk("fir_config", ADDR_FIR_CONFIG, 32'h0, 1'b0);
    rd_chk("status", ADDR_STATUS, 32'h0, 1'b0);
    print_verdict();
  end
endmodule
